// [hdl/adcc_pkg.sv]
// Purpose: Shared constants and types for the converter control block.
// Assumes: Byte-wide register port, 16-bit peripheral address.
// Notes:   Tick counts are in converter clock periods.
package adcc_pkg;

  // Register addresses in the peripheral space.
  localparam logic [15:0] ADCC_ADDR_CSR   = 16'h0070;
  localparam logic [15:0] ADCC_ADDR_UPPER = 16'h0071;
  localparam logic [15:0] ADCC_ADDR_LOWER = 16'h0072;

  // Field positions inside the control/status register.
  localparam int ADCC_CSR_DONE_BIT  = 7;
  localparam int ADCC_CSR_SPEED_BIT = 6;
  localparam int ADCC_CSR_ON_BIT    = 5;
  localparam int ADCC_CSR_RSVD_BIT  = 4;
  localparam int ADCC_CSR_CH_MSB    = 3;
  localparam int ADCC_CSR_CH_LSB    = 0;

  // Reset values.
  localparam logic [7:0] ADCC_CSR_RESET    = 8'h00;
  localparam logic [9:0] ADCC_RESULT_RESET = 10'h000;
  localparam logic [7:0] ADCC_RD_IDLE      = 8'h00;

  // Conversion geometry and timing counts.
  localparam int         ADCC_RES_BITS     = 10;
  localparam logic [2:0] ADCC_SAMPLE_TICKS = 3'h4;
  localparam logic [1:0] ADCC_STEP_TICKS   = 2'h3;
  localparam logic [1:0] ADCC_DIV_SLOW     = 2'h3;
  localparam logic [1:0] ADCC_DIV_FAST     = 2'h1;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'b00,
    ADCC_SAMPLE  = 2'b01,
    ADCC_CONVERT = 2'b10
  } adcc_state_t;

endpackage : adcc_pkg

// [hdl/adcc_clk_if.sv]
// Purpose: Carries the converter clock request and tick between modules.
// Assumes: Single CPU clock domain.
// Notes:   The tick is a one-cycle pulse per converter clock period.
`timescale 1ns/1ps
`default_nettype none
interface adcc_clk_if;
  logic fast_sel;
  logic run;
  logic tick;

  modport ctrl (output fast_sel, output run, input tick);
  modport div  (input fast_sel, input run, output tick);
endinterface : adcc_clk_if
`default_nettype wire

// [hdl/adcc_clk_div.sv]
// Purpose: Derives the converter clock tick from the CPU clock.
// Assumes: Divide by four when fast_sel is low, by two when high.
// Notes:   The divider holds at zero while the converter is off.
`timescale 1ns/1ps
`default_nettype none
module adcc_clk_div
  import adcc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  adcc_clk_if.div    cif
);

  logic [1:0] div_cnt_reg;
  logic [1:0] div_last;
  logic       tick_reg;

  // Terminal count picks the division ratio.
  assign div_last = cif.fast_sel ? ADCC_DIV_FAST : ADCC_DIV_SLOW;

  // Free counter that wraps at the terminal count while running.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 2'h0;
    end else if (!cif.run || div_cnt_reg >= div_last) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // One tick per converter clock period.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= cif.run && (div_cnt_reg >= div_last);
    end
  end

  assign cif.tick = tick_reg;

endmodule : adcc_clk_div
`default_nettype wire

// [hdl/adcc_top.sv]
// Purpose: Control, status and result registers of a 10-bit SAR converter.
// Assumes: Analog comparator and trial DAC sit outside; comparator is async.
// Notes:   Registers are byte wide; reads return data one cycle later.
//
// Function
// - The done flag is set when a conversion ends and cleared by reading the upper result or writing the CSR.
// - The converter clock is the CPU clock over four when the speed bit is 0 and over two when it is 1.
// - Writing the on bit high enables and starts conversion, writing it low disables and stops it.
// - The four-bit channel field is a binary channel number, 0 for input zero up to 15 for input fifteen.
// - The upper result register shows result bits 9 to 2 in bits 7 to 0.
// - The lower result register reads zero in bits 7 to 2.
// - The lower result register shows result bits 1 and 0 in bits 1 and 0.
// - All CSR bits but the done flag and the reserved bit 4 are writable, and both result registers are read only.
// - Reset clears the CSR and both result registers to zero.
// - The CSR sits at 0070h, the upper result at 0071h and the lower result at 0072h.
// - While enabled the converter repeats conversions of the selected channel back to back.
// - A channel change abandons the current conversion, clears the done flag and restarts on the new channel.
// - The result saturates at all ones above the upper reference and all zeros below the lower one.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rd_data,
  input  wire logic        comp_above,
  output logic      [3:0]  channel_field,
  output logic             converter_on,
  output logic             sample_hold,
  output logic      [9:0]  trial_code
);

  // Address decode shared by the read and write paths.
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction : addr_is

  adcc_clk_if cif ();

  adcc_state_t state_reg;
  adcc_state_t state_next;
  logic        done_flag_reg;
  logic        speed_reg;
  logic        on_reg;
  logic [3:0]  chan_reg;
  logic [9:0]  result_reg;
  logic [7:0]  rd_data_reg;
  logic [9:0]  trial_reg;
  logic [9:0]  trial_next;
  logic [3:0]  bit_idx_reg;
  logic [2:0]  sample_cnt_reg;
  logic [1:0]  step_cnt_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync3_reg;
  logic        comp_filt_reg;
  logic        sample_hold_reg;
  logic        csr_wr;
  logic        upper_rd;
  logic        chan_change;
  logic        restart;
  logic        stop_req;
  logic        decide;
  logic        conv_end;
  logic [9:0]  decided_code;
  logic [9:0]  bit_mask;

  // Converter clock divider, steered by the speed bit and the on bit.
  // The divider holds while the converter is off, so the first tick after a
  // start arrives one CPU clock late. Software sees this only as a slightly
  // longer first sample phase. A speed change moves the terminal count at once, but
  // the counter wraps at or above it, so a period never drops below two CPU clocks.
  adcc_clk_div u_div (
    .clk  (clk),
    .rstn (rstn),
    .cif  (cif.div)
  );

  assign cif.fast_sel = speed_reg;
  assign cif.run      = on_reg;

  // Bus access qualifiers.
  assign csr_wr      = wr_stb && addr_is(addr, ADCC_ADDR_CSR);
  assign upper_rd    = rd_stb && addr_is(addr, ADCC_ADDR_UPPER);
  assign chan_change = csr_wr && on_reg && wr_data[ADCC_CSR_ON_BIT]
                       && (wr_data[ADCC_CSR_CH_MSB:ADCC_CSR_CH_LSB] != chan_reg);

  // A fresh start happens when the converter is switched on or the channel moves.
  assign restart = chan_change
                   || (csr_wr && !on_reg && wr_data[ADCC_CSR_ON_BIT]);

  // A write that clears the on bit stops the sequencer at once.
  // It also cancels a conversion end that falls in the same cycle. A stopped
  // converter therefore never reports a result that software no longer expects.
  assign stop_req = csr_wr && !wr_data[ADCC_CSR_ON_BIT];

  // Speed bit is plain software storage.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      speed_reg <= ADCC_CSR_RESET[ADCC_CSR_SPEED_BIT];
    end else if (csr_wr) begin
      speed_reg <= wr_data[ADCC_CSR_SPEED_BIT];
    end
  end

  // On bit enables the converter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_reg <= ADCC_CSR_RESET[ADCC_CSR_ON_BIT];
    end else if (csr_wr) begin
      on_reg <= wr_data[ADCC_CSR_ON_BIT];
    end
  end

  // Channel field selects the analog input by its binary value.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_reg <= ADCC_CSR_RESET[ADCC_CSR_CH_MSB:ADCC_CSR_CH_LSB];
    end else if (csr_wr) begin
      chan_reg <= wr_data[ADCC_CSR_CH_MSB:ADCC_CSR_CH_LSB];
    end
  end

  // Three-stage synchroniser for the asynchronous comparator output.
  // The first stage may go metastable, so only the second stage reads it.
  // The third stage exists only for the agreement test below. That test turns
  // a one-cycle glitch of the comparator into no change at all.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= comp_above;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // The comparator level is accepted once the last two stages agree.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comp_filt_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      comp_filt_reg <= sync3_reg;
    end
  end

  // A decision falls on the last tick of each successive-approximation step.
  // At the fast speed a step is six CPU clocks. The comparator answer needs one
  // clock in the analog path, three in the synchroniser and one in the filter,
  // so the filtered level is ready just in time for the decision.
  assign decide   = (state_reg == ADCC_CONVERT) && cif.tick
                    && (step_cnt_reg == ADCC_STEP_TICKS - 2'h1);

  // The end is dropped when the same write restarts or stops the converter.
  assign conv_end = decide && (bit_idx_reg == 4'h0) && !restart && !stop_req;

  // Mask of the bit under trial.
  assign bit_mask = 10'h001 << bit_idx_reg;

  // Keep the trial bit if the input is above it, else drop it.
  // An input above the top reference keeps every bit, one below drops every bit.
  assign decided_code = comp_filt_reg ? trial_reg : (trial_reg & ~bit_mask);

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADCC_IDLE: begin
        if (restart) begin
          state_next = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE: begin
        if (cif.tick && sample_cnt_reg == ADCC_SAMPLE_TICKS - 3'h1) begin
          state_next = ADCC_CONVERT;
        end
      end
      ADCC_CONVERT: begin
        if (conv_end) begin
          state_next = ADCC_SAMPLE;
        end
      end
      default: begin
        state_next = ADCC_IDLE;
      end
    endcase
    if (restart) begin
      state_next = ADCC_SAMPLE;
    end
    if (stop_req) begin
      state_next = ADCC_IDLE;
    end
  end

  // Sequencer state register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ADCC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sample phase counter in converter ticks.
  // A restart during sampling begins the full sample phase again, so a
  // channel change never gets a shortened sample of the new input.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_cnt_reg <= 3'h0;
    end else if (state_next != ADCC_SAMPLE || state_reg != ADCC_SAMPLE || restart) begin
      sample_cnt_reg <= 3'h0;
    end else if (cif.tick) begin
      sample_cnt_reg <= sample_cnt_reg + 3'h1;
    end
  end

  // Step counter gives the comparator time to settle through the synchroniser.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt_reg <= 2'h0;
    end else if (state_next != ADCC_CONVERT || state_reg != ADCC_CONVERT || decide) begin
      step_cnt_reg <= 2'h0;
    end else if (cif.tick) begin
      step_cnt_reg <= step_cnt_reg + 2'h1;
    end
  end

  // Bit index walks from the top bit down to bit zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_idx_reg <= 4'h0;
    end else if (state_next == ADCC_CONVERT && state_reg != ADCC_CONVERT) begin
      bit_idx_reg <= 4'(ADCC_RES_BITS - 1);
    end else if (decide && bit_idx_reg != 4'h0) begin
      bit_idx_reg <= bit_idx_reg - 4'h1;
    end
  end

  // Trial code: start at mid scale, then settle one bit per step.
  // Leaving the convert phase wins over a decision in the same cycle, so a
  // stop or restart always returns the DAC code to zero.
  always_comb begin
    trial_next = trial_reg;
    if (state_next == ADCC_CONVERT && state_reg != ADCC_CONVERT) begin
      trial_next = 10'h200;
    end else if (state_next != ADCC_CONVERT) begin
      trial_next = 10'h000;
    end else if (decide && bit_idx_reg != 4'h0) begin
      trial_next = decided_code | (bit_mask >> 1);
    end
  end

  // Trial code register drives the comparison DAC.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trial_reg <= 10'h000;
    end else begin
      trial_reg <= trial_next;
    end
  end

  // Sample and hold switch closes during the sample phase.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_hold_reg <= 1'b0;
    end else begin
      sample_hold_reg <= (state_next == ADCC_SAMPLE);
    end
  end

  // The result is not latched against reads; each conversion overwrites it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= ADCC_RESULT_RESET;
    end else if (conv_end) begin
      result_reg <= decided_code;
    end
  end

  // Done flag: set at conversion end, cleared by an upper read or CSR write.
  // A setting event wins over a clear in the same cycle.
  // Losing a completion would leave software polling for a result that has
  // already arrived, while a stale flag costs only one extra read.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_flag_reg <= ADCC_CSR_RESET[ADCC_CSR_DONE_BIT];
    end else if (conv_end) begin
      done_flag_reg <= 1'b1;
    end else if (upper_rd || csr_wr) begin
      done_flag_reg <= 1'b0;
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  // Returning zero between reads keeps the shared read bus quiet. The reserved
  // control bit always reads back as zero, whatever software wrote there.
  // Unmapped addresses read as zero and never disturb any state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= ADCC_RD_IDLE;
    end else if (!rd_stb) begin
      rd_data_reg <= ADCC_RD_IDLE;
    end else if (addr_is(addr, ADCC_ADDR_CSR)) begin
      rd_data_reg <= {done_flag_reg, speed_reg, on_reg, 1'b0, chan_reg};
    end else if (addr_is(addr, ADCC_ADDR_UPPER)) begin
      rd_data_reg <= result_reg[9:2];
    end else if (addr_is(addr, ADCC_ADDR_LOWER)) begin
      rd_data_reg <= {6'h00, result_reg[1:0]};
    end else begin
      rd_data_reg <= ADCC_RD_IDLE;
    end
  end

  // Outputs come straight from flip-flops.
  // The channel select and the on bit drive the analog mux and the bias
  // enables directly. Keeping them registered avoids glitches on those pins.
  assign rd_data       = rd_data_reg;
  assign channel_field = chan_reg;
  assign converter_on  = on_reg;
  assign sample_hold   = sample_hold_reg;
  assign trial_code    = trial_reg;

endmodule : adcc_top
`default_nettype wire

// [sim/adcc_monitor.sv]
// Purpose: Port-level checker for the converter control block.
// Assumes: One clock domain, strobes never both high.
// Notes:   Speed bit is shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module adcc_monitor
  import adcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wr_data,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rd_data,
  input wire logic        comp_above,
  input wire logic [3:0]  channel_field,
  input wire logic        converter_on,
  input wire logic        sample_hold,
  input wire logic [9:0]  trial_code
);
  logic spd_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Shadow of the speed bit, so sample length can be judged.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) spd_reg <= 1'b0;
    else if (wr_stb && addr == ADCC_ADDR_CSR) spd_reg <= wr_data[6];
  end

  rd_idle_zero_a: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
    else $error("read data not idle");
  lower_high_zero_a: assert property ($past(rd_stb) && $past(addr) == ADCC_ADDR_LOWER
    |-> rd_data[7:2] == 6'h00) else $error("lower result high bits set");
  unmapped_read_a: assert property ($past(rd_stb) && $past(addr) != ADCC_ADDR_CSR
    && $past(addr) != ADCC_ADDR_UPPER && $past(addr) != ADCC_ADDR_LOWER |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  channel_write_a: assert property (wr_stb && addr == ADCC_ADDR_CSR
    |=> channel_field == $past(wr_data[3:0])) else $error("channel not taken");
  on_write_a: assert property (wr_stb && addr == ADCC_ADDR_CSR
    |=> converter_on == $past(wr_data[5])) else $error("on bit not taken");
  off_trial_zero_a: assert property (!converter_on |-> trial_code == 10'h000)
    else $error("trial code while off");
  start_sample_a: assert property (wr_stb && addr == ADCC_ADDR_CSR && wr_data[5]
    && !converter_on |=> sample_hold) else $error("no sample after start");
  csr_readback_a: assert property ($past(rd_stb) && $past(addr) == ADCC_ADDR_CSR
    |-> rd_data[6:0] == {spd_reg, converter_on, 1'b0, channel_field}) else $error("csr readback wrong");
  // Four ticks of two clocks: seven to ten clocks, the start delay included.
  sample_fast_a: assert property (disable iff (!rstn || wr_stb) $rose(sample_hold) && spd_reg
    |-> sample_hold[*7] ##[1:4] !sample_hold) else $error("fast sample length");
  // Four ticks of four clocks: thirteen to seventeen clocks, the start delay included.
  sample_slow_a: assert property (disable iff (!rstn || wr_stb) $rose(sample_hold) && !spd_reg
    |-> sample_hold[*8] ##1 sample_hold[*5] ##[1:5] !sample_hold) else $error("slow sample length");
endmodule : adcc_monitor
`default_nettype wire

// [sim/adcc_analog_model.sv]
// Purpose: Analog mux and comparator seen by the converter.
// Assumes: One fixed level per channel.
// Notes:   Output answers one clock after mux or trial code moves.
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
  input wire logic       clk,
  input wire logic [3:0] channel_field,
  input wire logic [9:0] trial_code,
  input wire logic [9:0] lvl [16],
  output var logic       comp_above
);
  // Compare the selected level against the trial code.
  always @(posedge clk) begin
    comp_above <= lvl[channel_field] >= trial_code;
  end
endmodule : adcc_analog_model
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the converter control block.
// Assumes: Bus reads return data one cycle after the strobe edge.
// Notes:   Levels are random; channels 0 and 15 sit at the rails.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rd_data;
  logic        comp_above;
  logic [3:0]  channel_field;
  logic        converter_on;
  logic        sample_hold;
  logic [9:0]  trial_code;
  logic [9:0]  lvl [16];
  logic [3:0]  ch;
  logic        spd;
  logic [9:0]  v;
  int          miscompares = 0;
  int          checks = 0;

  adcc_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .comp_above(comp_above), .channel_field(channel_field), .converter_on(converter_on),
    .sample_hold(sample_hold), .trial_code(trial_code));
  adcc_analog_model u_model (.clk(clk), .channel_field(channel_field), .trial_code(trial_code), .lvl(lvl),
    .comp_above(comp_above));

  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;

  // Control word with the converter on; the reserved bit is always written as zero.
  function automatic logic [7:0] csr_of(input logic s, input logic [3:0] c);
    return {1'b0, s, 1'b1, 1'b0, c};
  endfunction : csr_of

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
    logic [7:0] g;
    rd(a, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : rc

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic wait_done;
    logic [7:0] s;
    for (int k = 0; k < 200; k++) begin
      rd(ADCC_ADDR_CSR, s);
      if (s[7] === 1'b1) return;
    end
    miscompares++;
    complete_run();
  endtask : wait_done

  // Main sequence: reset values, CSR write mask, conversions, then read-only refusals and stop.
  initial begin
    void'($urandom(32'hd2d7));
    foreach (lvl[i]) lvl[i] = 10'($urandom());
    lvl[0] = 10'h3ff;
    lvl[15] = 10'h000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rc(ADCC_ADDR_CSR, 8'h00, "csr reset");
    rc(ADCC_ADDR_UPPER, 8'h00, "upper reset");
    rc(ADCC_ADDR_LOWER, 8'h00, "lower reset");
    rc(16'h0073, 8'h00, "unmapped read");
    wr(ADCC_ADDR_CSR, 8'hef);
    rc(ADCC_ADDR_CSR, 8'h6f, "csr writable bits");
    for (int i = 0; i < 8; i++) begin
      ch  = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom());
      spd = i[0];
      v   = lvl[ch];
      wr(ADCC_ADDR_CSR, csr_of(spd, ch ^ 4'h1));
      repeat (20) @(posedge clk);
      wr(ADCC_ADDR_CSR, csr_of(spd, ch));
      rc(ADCC_ADDR_CSR, csr_of(spd, ch), "csr after channel change");
      wait_done();
      rc(ADCC_ADDR_LOWER, {6'h00, v[1:0]}, "result lower");
      rc(ADCC_ADDR_UPPER, v[9:2], "result upper");
      rc(ADCC_ADDR_CSR, csr_of(spd, ch), "done after upper read");
      wait_done();
      wr(ADCC_ADDR_CSR, csr_of(spd, ch));
      rc(ADCC_ADDR_CSR, csr_of(spd, ch), "done after csr write");
    end
    wr(ADCC_ADDR_UPPER, 8'haa);
    wr(ADCC_ADDR_LOWER, 8'hff);
    rc(ADCC_ADDR_UPPER, v[9:2], "upper read only");
    rc(ADCC_ADDR_LOWER, {6'h00, v[1:0]}, "lower read only");
    wr(ADCC_ADDR_CSR, 8'h00);
    repeat (300) @(posedge clk);
    rc(ADCC_ADDR_CSR, 8'h00, "stopped");
    complete_run();
  end
endmodule : tb_top

bind adcc_top adcc_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .comp_above(comp_above), .channel_field(channel_field),
  .converter_on(converter_on), .sample_hold(sample_hold), .trial_code(trial_code));
`default_nettype wire
